// >>> src/bcrd_decoder.sv
// module: system-side address decoder and ready generator
`timescale 1ns/1ps
module bcrd_decoder
	import bcrd_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   resetn,
	bcrd_if.decoder                     bus,
	output logic [BCRD_LANES-1:0]       ram_we_n,     // per-lane write enable
	output logic                        eprom_sel,    // device selects
	output logic                        sram_sel,
	output logic                        periph_sel,
	input  wire logic [BCRD_DATA_W-1:0] dev_rdata     // selected device data
);
	// ========================================
	// state
	logic                     busy_ff, nxt_busy;   // cycle in progress
	logic [BCRD_WAIT_W-1:0]   wcnt_ff, nxt_wcnt;   // processor clocks left
	logic                     rdy_n_ff, nxt_rdy_n;
	logic                     half_n_ff, nxt_half_n;
	logic [BCRD_LANES-1:0]    we_n_ff, nxt_we_n;
	logic [2:0]               sel_ff, nxt_sel;     // eprom, sram, periph
	logic [BCRD_DATA_W-1:0]   rd_ff, nxt_rd;
	logic [BCRD_WAIT_W-1:0]   waits;               // decoded count
	logic [BCRD_REGION_W-1:0] region;
	logic [2:0]               sel_dec;
	logic                     start;

	// ========================================
	// address decode
	always_comb begin
		region  = bus.word_address[BCRD_ADDR_W-1 -: BCRD_REGION_W];
		sel_dec = 3'h0;
		waits   = BCRD_WAIT_UNMAP;
		unique case (region)
			BCRD_REG_EPROM: begin
				sel_dec = 3'h1;
				waits   = BCRD_WAIT_EPROM;
			end
			BCRD_REG_SRAM: begin
				sel_dec = 3'h2;
				waits   = BCRD_WAIT_SRAM;
			end
			BCRD_REG_PERIPH: begin
				sel_dec = 3'h4;
				waits   = BCRD_WAIT_PERIPH;
			end
			default: sel_dec = 3'h0;  // unmapped: no select
		endcase
	end

	// strobe seen on the processor clock edge closing T1
	assign start = !bus.addr_strobe_n && bus.proc_clk_en && !busy_ff;

	// ========================================
	// next-state logic
	always_comb begin
		nxt_busy   = busy_ff;
		nxt_wcnt   = wcnt_ff;
		nxt_rdy_n  = 1'b1;
		nxt_half_n = half_n_ff;
		nxt_we_n   = we_n_ff;
		nxt_sel    = sel_ff;
		nxt_rd     = rd_ff;
		if (start) begin
			nxt_busy   = 1'b1;
			// a down counter covers the largest count, a 5-bit one-hot
			// shifted by 5 would fall off the top and end the cycle early
			nxt_wcnt   = waits;
			nxt_sel    = sel_dec;
			nxt_half_n = ~sel_dec[0];
			nxt_we_n   = (bus.write_n_read && sel_dec[1]) ?
			             bus.byte_lane_enable_n : '1;
		end else if (busy_ff && !bus.proc_clk_en) begin
			// counts on first-half edges, so ready stands low exactly
			// through the edge at which the core samples it
			if (wcnt_ff == '0) begin
				nxt_rdy_n = 1'b0;
				nxt_busy  = 1'b0;
				nxt_rd    = dev_rdata;
			end else begin
				nxt_wcnt = wcnt_ff - BCRD_WAIT_W'(1);
			end
		end else if (busy_ff) begin
			nxt_rdy_n = rdy_n_ff;
		end
		if (!nxt_busy) begin
			nxt_we_n   = '1;
			nxt_sel    = 3'h0;
			nxt_half_n = nxt_rdy_n ? 1'b1 : half_n_ff;
		end
	end

	// ========================================
	// registers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			busy_ff   <= 1'b0;
			wcnt_ff   <= '0;
			rdy_n_ff  <= 1'b1;
			half_n_ff <= 1'b1;
			we_n_ff   <= '1;
			sel_ff    <= 3'h0;
			rd_ff     <= '0;
		end else begin
			busy_ff   <= nxt_busy;
			wcnt_ff   <= nxt_wcnt;
			rdy_n_ff  <= nxt_rdy_n;
			half_n_ff <= nxt_half_n;
			we_n_ff   <= nxt_we_n;
			sel_ff    <= nxt_sel;
			rd_ff     <= nxt_rd;
		end
	end

	// ========================================
	// outputs; pipelining kept off during bring-up
	assign bus.next_addr_request_n = 1'b1;
	assign bus.ready_n             = rdy_n_ff;
	assign bus.half_width_bus_n    = half_n_ff;
	assign bus.rdata               = rd_ff;
	assign ram_we_n                = we_n_ff;
	assign eprom_sel               = sel_ff[0];
	assign sram_sel                = sel_ff[1];
	assign periph_sel              = sel_ff[2];
endmodule // bcrd_decoder

// >>> src/bcrd_pkg.sv
// package: shared constants and types for the bus-cycle ready decoder
package bcrd_pkg;
	// ========================================
	// bus widths
	localparam int unsigned BCRD_ADDR_W  = 30;  // word address, bits 2..31
	localparam int unsigned BCRD_LANES   = 4;   // byte lanes of the 32-bit bus
	localparam int unsigned BCRD_DATA_W  = 32;
	localparam int unsigned BCRD_WAIT_W  = 4;   // wait-state count width
	localparam int unsigned BCRD_REGION_W = 4;  // top address bits decoded

	// ========================================
	// address map: top four bits of the word address select a device
	localparam logic [3:0] BCRD_REG_EPROM = 4'hF;  // boot store, 16-bit wide
	localparam logic [3:0] BCRD_REG_SRAM  = 4'h0;  // byte-writable ram
	localparam logic [3:0] BCRD_REG_PERIPH = 4'h8; // slow peripherals

	// ========================================
	// wait-state counts per device
	localparam logic [3:0] BCRD_WAIT_EPROM  = 4'h3;
	localparam logic [3:0] BCRD_WAIT_SRAM   = 4'h0;
	localparam logic [3:0] BCRD_WAIT_PERIPH = 4'h5;
	localparam logic [3:0] BCRD_WAIT_UNMAP  = 4'h2;  // default, avoids hang

	// ========================================
	// bus state machine codes (processor side)
	typedef enum logic [1:0] {
		BCRD_TI = 2'b00,  // idle
		BCRD_T1 = 2'b01,  // address state
		BCRD_T2 = 2'b10   // second_bus_state and its wait states
	} bcrd_bus_t;
endpackage

// >>> src/bcrd_if.sv
// interface: processor local bus between core end and decoder end
`timescale 1ns/1ps
interface bcrd_if;
	import bcrd_pkg::*;
	logic [BCRD_ADDR_W-1:0] word_address;        // word address
	logic [BCRD_LANES-1:0]  byte_lane_enable_n;  // active-low lane enables
	logic                   addr_strobe_n;       // one processor clock per cycle
	logic                   write_n_read;        // 1 = write
	logic [BCRD_DATA_W-1:0] wdata;               // write data
	logic [BCRD_DATA_W-1:0] rdata;               // read data
	logic                   ready_n;             // cycle done, active low
	logic                   half_width_bus_n;    // 16-bit target, active low
	logic                   next_addr_request_n; // held high: no pipelining
	logic                   proc_clk_en;         // internal-clock phase mark

	modport core (
		output word_address, byte_lane_enable_n, addr_strobe_n,
		output write_n_read, wdata, proc_clk_en,
		input  rdata, ready_n, half_width_bus_n, next_addr_request_n
	);
	modport decoder (
		input  word_address, byte_lane_enable_n, addr_strobe_n,
		input  write_n_read, wdata, proc_clk_en,
		output rdata, ready_n, half_width_bus_n, next_addr_request_n
	);
endinterface

// >>> src/bcrd_core.sv
// module: processor-side bus cycle engine on the double-rate clock
//
// Function
// - system holds next-address request negated
// - wait state per unready clock after T2
// - cycle stays open until ready seen
// - decoder picks wait count from address
// - decoder asserts ready after counted waits
// - separate ram write enable per lane
// - decoder flags 16-bit targets
// - 30-bit word address plus four lane enables
// - internal clock is half double-rate clock
// - address strobe once per bus cycle
`timescale 1ns/1ps
module bcrd_core
	import bcrd_pkg::*;
(
	input  wire logic                   core_clk,     // double_rate_clock
	input  wire logic                   resetn,
	bcrd_if.core                        bus,
	input  wire logic                   req_valid,    // user cycle request
	output logic                        req_ready,    // request accepted
	input  wire logic [BCRD_ADDR_W-1:0] req_addr,
	input  wire logic [BCRD_LANES-1:0]  req_lanes,    // active-high lanes
	input  wire logic                   req_write,
	input  wire logic [BCRD_DATA_W-1:0] req_wdata,
	output logic                        done_pulse,   // cycle ended
	output logic [BCRD_DATA_W-1:0]      done_rdata,
	output logic                        done_half     // ended as 16-bit
);
	// ========================================
	// state
	logic                   phase_ff, nxt_phase;     // internal clock phase
	bcrd_bus_t              st_ff, nxt_st;           // bus state
	logic [BCRD_ADDR_W-1:0] addr_ff, nxt_addr;       // held word address
	logic [BCRD_LANES-1:0]  be_n_ff, nxt_be_n;       // held lane enables
	logic                   wr_ff, nxt_wr;
	logic [BCRD_DATA_W-1:0] wd_ff, nxt_wd;
	logic                   ads_n_ff, nxt_ads_n;     // strobe register
	logic                   done_ff, nxt_done;
	logic [BCRD_DATA_W-1:0] rd_ff, nxt_rd;
	logic                   half_ff, nxt_half;

	// ========================================
	// next-state logic
	always_comb begin
		nxt_phase = ~phase_ff;
		nxt_st    = st_ff;
		nxt_addr  = addr_ff;
		nxt_be_n  = be_n_ff;
		nxt_wr    = wr_ff;
		nxt_wd    = wd_ff;
		nxt_ads_n = ads_n_ff;
		nxt_done  = 1'b0;
		nxt_rd    = rd_ff;
		nxt_half  = half_ff;
		req_ready = 1'b0;
		// bus states advance only on the second half of a processor clock
		if (phase_ff) begin
			unique case (st_ff)
				BCRD_TI: begin
					// non-pipelined only: next_addr_request_n ignored
					if (req_valid) begin
						req_ready = 1'b1;
						nxt_st    = BCRD_T1;
						nxt_addr  = req_addr;
						nxt_be_n  = ~req_lanes;
						nxt_wr    = req_write;
						nxt_wd    = req_wdata;
						nxt_ads_n = 1'b0;
					end
				end
				BCRD_T1: begin
					nxt_st    = BCRD_T2;
					nxt_ads_n = 1'b1;  // strobe lasts one processor clock
				end
				BCRD_T2: begin
					// no timeout: wait here until ready sampled low
					if (!bus.ready_n) begin
						nxt_st   = BCRD_TI;
						nxt_done = 1'b1;
						nxt_rd   = bus.rdata;
						nxt_half = ~bus.half_width_bus_n;
						nxt_be_n = {BCRD_LANES{1'b1}};
					end
					// else stay: one more wait state
				end
				default: nxt_st = BCRD_TI;
			endcase
		end
	end

	// ========================================
	// registers
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			phase_ff <= 1'b0;
			st_ff    <= BCRD_TI;
			addr_ff  <= '0;
			be_n_ff  <= '1;
			wr_ff    <= 1'b0;
			wd_ff    <= '0;
			ads_n_ff <= 1'b1;
			done_ff  <= 1'b0;
			rd_ff    <= '0;
			half_ff  <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			st_ff    <= nxt_st;
			addr_ff  <= nxt_addr;
			be_n_ff  <= nxt_be_n;
			wr_ff    <= nxt_wr;
			wd_ff    <= nxt_wd;
			ads_n_ff <= nxt_ads_n;
			done_ff  <= nxt_done;
			rd_ff    <= nxt_rd;
			half_ff  <= nxt_half;
		end
	end

	// ========================================
	// outputs
	assign bus.word_address       = addr_ff;
	assign bus.byte_lane_enable_n = be_n_ff;
	assign bus.addr_strobe_n      = ads_n_ff;
	assign bus.write_n_read       = wr_ff;
	assign bus.wdata              = wd_ff;
	assign bus.proc_clk_en        = phase_ff;
	assign done_pulse             = done_ff;
	assign done_rdata             = rd_ff;
	assign done_half              = half_ff;
endmodule // bcrd_core

// >>> verification/bcrd_checker.sv
// checker: timing of the shared bus between core end and decoder end
`timescale 1ns/1ps
module bcrd_checker
	import bcrd_pkg::*;
(
	input wire logic                   core_clk,
	input wire logic                   resetn,
	input wire logic [BCRD_ADDR_W-1:0] word_address,
	input wire logic [BCRD_LANES-1:0]  byte_lane_enable_n,
	input wire logic                   addr_strobe_n,
	input wire logic                   ready_n,
	input wire logic                   half_width_bus_n,
	input wire logic                   next_addr_request_n,
	input wire logic                   proc_clk_en
);
	// ========================================
	// cycle tracking
	logic       busy_ff, nxt_busy; // strobe seen, ready not yet
	logic [4:0] cnt_ff, nxt_cnt;   // clocks since strobe
	logic [3:0] waits;             // waits of the addressed region
	// open on strobe, close on ready; count wraps harmlessly when idle
	always_comb begin
		nxt_busy = busy_ff;
		nxt_cnt = cnt_ff + 5'h01;
		if (!addr_strobe_n && !busy_ff) begin
			nxt_busy = 1'b1;
			nxt_cnt = 5'h00;
		end else if (!ready_n) begin
			nxt_busy = 1'b0;
		end
		case (word_address[29:26])
			BCRD_REG_EPROM:  waits = BCRD_WAIT_EPROM;
			BCRD_REG_SRAM:   waits = BCRD_WAIT_SRAM;
			BCRD_REG_PERIPH: waits = BCRD_WAIT_PERIPH;
			default:         waits = BCRD_WAIT_UNMAP;
		endcase
	end
	// registers only
	always_ff @(posedge core_clk) begin
		busy_ff <= resetn ? nxt_busy : 1'b0;
		cnt_ff <= resetn ? nxt_cnt : 5'h00;
	end
	// ========================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence strobe_two_s;
		!addr_strobe_n ##1 addr_strobe_n;
	endsequence
	na_held_high_a: assert property (next_addr_request_n)
		else $error("next address request asserted");
	phase_toggle_a: assert property ($past(resetn) |->
		proc_clk_en != $past(proc_clk_en)) else $error("phase stuck");
	strobe_width_a: assert property ($fell(addr_strobe_n) |=>
		strobe_two_s) else $error("strobe width wrong");
	strobe_once_a: assert property (busy_ff && $past(busy_ff) |->
		addr_strobe_n) else $error("second strobe in cycle");
	ready_pulse_a: assert property (!ready_n |=> ready_n)
		else $error("ready longer than one clock");
	ready_in_cycle_a: assert property (!ready_n |-> busy_ff)
		else $error("ready outside a cycle");
	wait_count_a: assert property ($fell(ready_n) |->
		cnt_ff == {waits, 1'b0} + 5'h02)
		else $error("wait count wrong for region");
	cycle_bound_a: assert property ($fell(addr_strobe_n) |->
		##[3:28] !ready_n) else $error("cycle never ends");
	half_width_a: assert property (!ready_n |->
		half_width_bus_n == (word_address[29:26] != BCRD_REG_EPROM))
		else $error("half width flag wrong");
	addr_held_a: assert property (busy_ff |->
		$stable(word_address) && $stable(byte_lane_enable_n))
		else $error("address moved in cycle");
endmodule // bcrd_checker

// >>> verification/tb_top.sv
// testbench: both bus ends joined, corner and random cycles checked
`timescale 1ns/1ps
module tb_top;
	import bcrd_pkg::*;
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin \
	errors++; $display("wrong value at %0t: %s", $time, m); end end
	// ========================================
	// signals
	logic                   core_clk  = 1'b0;
	logic                   resetn    = 1'b0;
	logic                   req_valid = 1'b0;
	logic                   req_write = 1'b0;
	logic [BCRD_ADDR_W-1:0] req_addr  = '0;
	logic [BCRD_LANES-1:0]  req_lanes = '0;
	logic [BCRD_DATA_W-1:0] req_wdata = '0;
	logic [BCRD_DATA_W-1:0] dev_rdata = '0;
	logic [BCRD_DATA_W-1:0] done_rdata;
	logic [BCRD_LANES-1:0]  ram_we_n;
	logic                   req_ready, done_pulse, done_half;
	logic                   eprom_sel, sram_sel, periph_sel;
	logic [3:0]             rg;
	logic [3:0] regs [3] = '{BCRD_REG_SRAM, BCRD_REG_EPROM, BCRD_REG_PERIPH};
	int                     errors = 0, check_count = 0;
	int                     seed = 14, base = -1;
	// ========================================
	// ends, joined by one interface
	always #5 core_clk = ~core_clk;
	bcrd_if bus_if ();
	bcrd_core bcrd_core_inst (.core_clk(core_clk), .resetn(resetn),
		.bus(bus_if), .req_valid(req_valid), .req_ready(req_ready),
		.req_addr(req_addr), .req_lanes(req_lanes), .req_write(req_write),
		.req_wdata(req_wdata), .done_pulse(done_pulse),
		.done_rdata(done_rdata), .done_half(done_half));
	bcrd_decoder bcrd_decoder_inst (.core_clk(core_clk), .resetn(resetn),
		.bus(bus_if), .ram_we_n(ram_we_n), .eprom_sel(eprom_sel),
		.sram_sel(sram_sel), .periph_sel(periph_sel), .dev_rdata(dev_rdata));
	bcrd_checker bcrd_checker_inst (.core_clk(core_clk), .resetn(resetn),
		.word_address(bus_if.word_address),
		.byte_lane_enable_n(bus_if.byte_lane_enable_n),
		.addr_strobe_n(bus_if.addr_strobe_n), .ready_n(bus_if.ready_n),
		.half_width_bus_n(bus_if.half_width_bus_n),
		.next_addr_request_n(bus_if.next_addr_request_n),
		.proc_clk_en(bus_if.proc_clk_en));
	// ========================================
	// expectations per region
	function automatic logic [3:0] waits_of(input logic [3:0] r);
		case (r)
			BCRD_REG_EPROM:  return BCRD_WAIT_EPROM;
			BCRD_REG_SRAM:   return BCRD_WAIT_SRAM;
			BCRD_REG_PERIPH: return BCRD_WAIT_PERIPH;
			default:         return BCRD_WAIT_UNMAP;
		endcase
	endfunction
	// one bus cycle: request held until taken, then watched to its end
	task automatic run(input logic [3:0] r, input logic [3:0] ln,
		input logic wr);
		logic [3:0] we_acc;
		logic [2:0] sel_acc;
		int n;
		we_acc = 4'hF;
		sel_acc = 3'h0;
		n = 0;
		@(negedge core_clk);
		req_addr = {r, 26'($random(seed))};
		req_lanes = ln;
		req_write = wr;
		req_wdata = $random(seed);
		dev_rdata = $random(seed);
		req_valid = 1'b1;
		#1;
		while (req_ready !== 1'b1 && n < 8) begin
			@(negedge core_clk);
			#1;
			n++;
		end
		@(negedge core_clk);
		req_valid = 1'b0;
		n = 1;
		while (done_pulse !== 1'b1 && n < 60) begin
			we_acc &= ram_we_n;
			sel_acc |= {eprom_sel, sram_sel, periph_sel};
			if (bus_if.addr_strobe_n === 1'b0) begin
				`CHK(bus_if.word_address, req_addr, "address")
				`CHK(bus_if.byte_lane_enable_n, ~ln, "lanes")
			end
			@(negedge core_clk);
			n++;
		end
		`CHK(done_pulse, 1'b1, "cycle end")
		n = n - 2 * int'(waits_of(r));
		if (base < 0) base = n;
		`CHK(n, base, "wait states")
		`CHK(done_half, r == BCRD_REG_EPROM, "half width")
		`CHK(we_acc, (wr && r == BCRD_REG_SRAM) ? ~ln : 4'hF, "we")
		`CHK(sel_acc, {r == BCRD_REG_EPROM, r == BCRD_REG_SRAM,
			r == BCRD_REG_PERIPH}, "select")
		if (!wr && (r == BCRD_REG_SRAM || r == BCRD_REG_PERIPH))
			`CHK(done_rdata, dev_rdata, "read data")
	endtask
	task automatic finish_test();
		$display("errors %0d, checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ========================================
	// corner cases, a mid-run reset, then random cycles
	initial begin
		repeat (5) @(negedge core_clk);
		resetn = 1'b1;
		run(BCRD_REG_SRAM, 4'h1, 1'b1);
		run(BCRD_REG_SRAM, 4'h8, 1'b1);
		run(4'h3, 4'hF, 1'b0);
		run(BCRD_REG_EPROM, 4'hF, 1'b0);
		run(BCRD_REG_PERIPH, 4'h5, 1'b1);
		resetn = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		for (int i = 0; i < 40; i++) begin
			rg = (i % 4 == 3) ? 4'($random(seed)) : regs[i % 4];
			run(rg, 4'($random(seed)), 1'($random(seed)));
		end
		finish_test();
	end
	// watchdog: 45 cycles of under 40 clocks each fit well inside
	initial begin
		#50000;
		errors++;
		finish_test();
	end
endmodule // tb_top
